/* File: rtl/fsk_serial_data_interface.sv */
`timescale 1ns/1ps
// Overview of operation
// RQ1: Select low gives mode 0: demodulated bits go straight to the data pin.
// RQ2: Select high gives mode 1: each received byte is held for serial reading.
// RQ3: Select high with both function selects low powers the whole chip down.
// RQ4: Mode 0 drives the shift clock pin with a strobe at each bit centre.
// RQ5: Mode 1 makes shift clock an input; host pulses shift the byte out.
// RQ6: FSK always uses the line path; tone detect uses line or hybrid path.
// RQ7: Demodulated asynchronous data is recovered at 1200 baud.
// RQ8: FSK or tone section powers down alone when not selected.
// RQ9: All bit timing counts ticks of the 3.579545MHz oscillator.
// RQ10: Mode 1 drops start bit, keeps eight data bits and stop bit.
// RQ11: Host gives eight shift pulses per word, a ninth for the stop bit.
// RQ12: Word ready idles high, pulses low half a bit at word end.
// RQ13: In mode 1 the first rising shift clock returns word ready high.
// RQ14: First data bit is on the pin at word ready; each rising edge advances it.
module fsk_serial_data_interface
    import fsk_if_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic arst_n_in,
    // Register bus
    input wire axil_req_t axil_req_in,
    output axil_rsp_t axil_rsp_out,
    output logic irq_out,
    // Mode and function pins
    input wire logic interface_select_in,
    input wire logic function_select_a_in,
    input wire logic function_select_b_in,
    input wire logic oscillator_input_in,
    // Front end
    input wire logic fsk_bit_in,
    input wire logic carrier_detect_n_in,
    input wire logic tone_detect_in,
    // Serial interface
    input wire logic shift_clock_pin_in,
    output logic shift_clock_pin_out,
    output logic shift_clock_pin_oe_out,
    output logic data_out,
    output logic word_ready_or_delayed_steer_n_out,
    // Power and path control
    output logic full_power_down_out,
    output logic fsk_power_down_out,
    output logic tone_power_down_out,
    output logic tone_use_hybrid_out
);

    // Function decode
    logic mode1;
    logic fsk_sel;
    logic full_pd;
    assign mode1 = interface_select_in;
    assign full_pd = interface_select_in & ~function_select_a_in & ~function_select_b_in; // see RQ3
    assign fsk_sel = function_select_a_in ~^ function_select_b_in;

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            full_power_down_out <= 1'b1;
            fsk_power_down_out <= 1'b1;
            tone_power_down_out <= 1'b1;
            tone_use_hybrid_out <= 1'b0;
        end else begin
            full_power_down_out <= full_pd; // see RQ3
            fsk_power_down_out <= full_pd | ~fsk_sel; // see RQ8
            tone_power_down_out <= full_pd | fsk_sel; // see RQ8
            tone_use_hybrid_out <= function_select_a_in & ~function_select_b_in; // see RQ6
        end
    end

    // Oscillator tick; bit timing never uses mclk directly
    logic osc_d_r;
    logic tick;
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            osc_d_r <= 1'b0;
        end else begin
            osc_d_r <= oscillator_input_in;
        end
    end
    assign tick = oscillator_input_in & ~osc_d_r; // see RQ9

    // Control register
    logic rx_enable_r;
    logic [INT_WIDTH-1:0] int_sts_r;
    logic [INT_WIDTH-1:0] int_mask_r;
    logic fsk_on;
    assign fsk_on = rx_enable_r & fsk_sel & ~full_pd & ~carrier_detect_n_in;

    // Receiver
    rx_state_t state_r;
    logic [11:0] tick_cnt_r;
    logic [3:0] bit_idx_r;
    logic [7:0] rx_byte_r;
    logic centre;
    logic word_done;
    logic [8:0] word;
    logic at_half;
    logic at_bit;
    assign at_half = tick && tick_cnt_r == HALF_TICKS - 12'h001;
    assign at_bit = tick && tick_cnt_r == BIT_TICKS - 12'h001;
    assign centre = (state_r == RX_START && at_half) || (state_r != RX_IDLE
        && state_r != RX_START && at_bit);
    assign word_done = state_r == RX_STOP && at_bit;
    assign word = {fsk_bit_in, rx_byte_r}; // see RQ10

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r <= RX_IDLE;
            tick_cnt_r <= 12'h000;
            bit_idx_r <= 4'h0;
            rx_byte_r <= 8'h00;
        end else if (!fsk_on) begin
            state_r <= RX_IDLE;
            tick_cnt_r <= 12'h000;
        end else begin
            if (tick) begin
                tick_cnt_r <= (at_bit || at_half && state_r == RX_START) ? 12'h000
                    : tick_cnt_r + 12'h001; // see RQ7
            end
            case (state_r)
                RX_IDLE: begin
                    tick_cnt_r <= 12'h000;
                    if (!fsk_bit_in) begin
                        state_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (at_half) begin
                        bit_idx_r <= 4'h0;
                        state_r <= fsk_bit_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (at_bit) begin
                        rx_byte_r <= {fsk_bit_in, rx_byte_r[7:1]}; // see RQ10
                        bit_idx_r <= bit_idx_r + 4'h1;
                        if (bit_idx_r == 4'(DATA_BITS - 1)) begin
                            state_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (at_bit) begin
                        state_r <= RX_IDLE;
                    end
                end
                default: state_r <= RX_IDLE;
            endcase
        end
    end

    // Shift clock pin: strobe out in mode 0, input in mode 1
    logic [11:0] strobe_cnt_r;
    logic sclk_d_r;
    logic sclk_rise;
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift_clock_pin_out <= 1'b0;
            shift_clock_pin_oe_out <= 1'b0;
            strobe_cnt_r <= 12'h000;
        end else begin
            shift_clock_pin_oe_out <= ~mode1; // see RQ4 RQ5
            if (mode1 || !fsk_on) begin
                shift_clock_pin_out <= 1'b0;
                strobe_cnt_r <= 12'h000;
            end else if (centre) begin
                shift_clock_pin_out <= 1'b1; // see RQ4
                strobe_cnt_r <= STROBE_TICKS;
            end else if (tick && strobe_cnt_r != 12'h000) begin
                strobe_cnt_r <= strobe_cnt_r - 12'h001;
                shift_clock_pin_out <= strobe_cnt_r != 12'h001;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= shift_clock_pin_in;
        end
    end
    // Schmitt input is already clean; edge only counts while the pin is ours to read
    assign sclk_rise = mode1 & ~shift_clock_pin_oe_out & shift_clock_pin_in & ~sclk_d_r;

    // Buffer and data pin
    logic [8:0] shift_r;
    logic [8:0] last_word_r;
    logic unread_r;
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift_r <= WORD_RESET;
            last_word_r <= WORD_RESET;
            data_out <= 1'b1;
        end else if (!mode1) begin
            data_out <= fsk_on ? fsk_bit_in : 1'b1; // see RQ1
        end else if (word_done) begin
            shift_r <= word; // see RQ2 RQ10
            last_word_r <= word;
            data_out <= word[0]; // see RQ14
        end else if (sclk_rise) begin
            shift_r <= {1'b1, shift_r[8:1]}; // see RQ11
            data_out <= shift_r[1]; // see RQ14
        end
    end

    // Word ready or delayed steer
    logic [11:0] ready_cnt_r;
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            word_ready_or_delayed_steer_n_out <= 1'b1;
            ready_cnt_r <= 12'h000;
        end else if (!fsk_sel || full_pd) begin
            word_ready_or_delayed_steer_n_out <= ~tone_detect_in;
            ready_cnt_r <= 12'h000;
        end else if (word_done) begin
            word_ready_or_delayed_steer_n_out <= 1'b0; // see RQ12
            ready_cnt_r <= HALF_TICKS;
        end else if (sclk_rise) begin
            word_ready_or_delayed_steer_n_out <= 1'b1; // see RQ13
            ready_cnt_r <= 12'h000;
        end else if (tick && ready_cnt_r != 12'h000) begin
            ready_cnt_r <= ready_cnt_r - 12'h001;
            word_ready_or_delayed_steer_n_out <= ready_cnt_r == 12'h001; // see RQ12
        end else if (ready_cnt_r == 12'h000) begin
            // Leaving tone mode must not leave a stale low on the pin
            word_ready_or_delayed_steer_n_out <= 1'b1; // see RQ12
        end
    end

    // Interrupt events
    logic [INT_WIDTH-1:0] events;
    assign events = {word_done & mode1 & unread_r, word_done & ~fsk_bit_in, word_done};

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            unread_r <= 1'b0;
        end else if (word_done && mode1) begin
            unread_r <= 1'b1;
        end else if (sclk_rise || !mode1) begin
            unread_r <= 1'b0;
        end
    end

    // AXI4-Lite slave
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic do_write;
    logic wr_ok;
    logic [31:0] rd_data;
    logic rd_ok;
    assign do_write = aw_have_r & w_have_r & ~axil_rsp_out.bvalid;
    assign wr_ok = aw_addr_r == REG_CTRL || aw_addr_r == REG_STATUS
        || aw_addr_r == REG_INT_STATUS || aw_addr_r == REG_INT_MASK
        || aw_addr_r == REG_LAST_WORD;

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        case (axil_req_in.araddr)
            REG_CTRL: rd_data = {31'h0, rx_enable_r};
            REG_STATUS: rd_data = {24'h0, unread_r, ~carrier_detect_n_in, state_r == RX_IDLE,
                fsk_power_down_out, tone_power_down_out, full_power_down_out, fsk_sel, mode1};
            REG_INT_STATUS: rd_data = {29'h0, int_sts_r};
            REG_INT_MASK: rd_data = {29'h0, int_mask_r};
            REG_LAST_WORD: rd_data = {23'h0, last_word_r};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            axil_rsp_out.awready <= 1'b0;
            axil_rsp_out.wready <= 1'b0;
            axil_rsp_out.bvalid <= 1'b0;
            axil_rsp_out.bresp <= RESP_OKAY;
        end else begin
            axil_rsp_out.awready <= ~aw_have_r & ~axil_rsp_out.awready;
            axil_rsp_out.wready <= ~w_have_r & ~axil_rsp_out.wready;
            if (axil_req_in.awvalid && axil_rsp_out.awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= axil_req_in.awaddr;
            end
            if (axil_req_in.wvalid && axil_rsp_out.wready) begin
                w_have_r <= 1'b1;
                w_data_r <= axil_req_in.wdata;
                w_strb_r <= axil_req_in.wstrb;
            end
            if (do_write) begin
                axil_rsp_out.bvalid <= 1'b1;
                axil_rsp_out.bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (axil_req_in.bready && axil_rsp_out.bvalid) begin
                axil_rsp_out.bvalid <= 1'b0;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            axil_rsp_out.arready <= 1'b0;
            axil_rsp_out.rvalid <= 1'b0;
            axil_rsp_out.rdata <= 32'h0000_0000;
            axil_rsp_out.rresp <= RESP_OKAY;
        end else begin
            axil_rsp_out.arready <= ~axil_rsp_out.rvalid & ~axil_rsp_out.arready
                & axil_req_in.arvalid;
            if (axil_req_in.arvalid && axil_rsp_out.arready) begin
                axil_rsp_out.rvalid <= 1'b1;
                axil_rsp_out.rdata <= rd_data;
                axil_rsp_out.rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (axil_req_in.rready && axil_rsp_out.rvalid) begin
                axil_rsp_out.rvalid <= 1'b0;
            end
        end
    end

    // Registers; an event in the clearing cycle survives
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_enable_r <= CTRL_RESET;
            int_mask_r <= INT_MASK_RESET;
            int_sts_r <= '0;
            irq_out <= 1'b0;
        end else begin
            if (do_write && w_strb_r[0] && aw_addr_r == REG_CTRL) begin
                rx_enable_r <= w_data_r[CTRL_RX_ENABLE_BIT];
            end
            if (do_write && w_strb_r[0] && aw_addr_r == REG_INT_MASK) begin
                int_mask_r <= w_data_r[INT_WIDTH-1:0];
            end
            if (do_write && w_strb_r[0] && aw_addr_r == REG_INT_STATUS) begin
                int_sts_r <= (int_sts_r & ~w_data_r[INT_WIDTH-1:0]) | events;
            end else begin
                int_sts_r <= int_sts_r | events;
            end
            irq_out <= |(int_sts_r & int_mask_r);
        end
    end

    // Checks
    property p_mode0_stream;
        @(posedge mclk_in) disable iff (!arst_n_in)
        !mode1 && fsk_on |=> data_out == $past(fsk_bit_in);
    endproperty
    a_mode0_stream: assert property (p_mode0_stream) else $error("mode 0 data lost"); // see RQ1

    property p_mode1_load;
        @(posedge mclk_in) disable iff (!arst_n_in)
        mode1 && word_done |=> shift_r == $past(word) && last_word_r == $past(word);
    endproperty
    a_mode1_load: assert property (p_mode1_load) else $error("buffer not loaded"); // see RQ2

    property p_full_pd;
        @(posedge mclk_in) disable iff (!arst_n_in)
        full_pd |=> full_power_down_out && fsk_power_down_out && tone_power_down_out;
    endproperty
    a_full_pd: assert property (p_full_pd) else $error("power down missed"); // see RQ3

    property p_strobe_out;
        @(posedge mclk_in) disable iff (!arst_n_in)
        !mode1 && fsk_on && centre ##1 !mode1 |-> shift_clock_pin_out && shift_clock_pin_oe_out;
    endproperty
    a_strobe_out: assert property (p_strobe_out) else $error("no centre strobe"); // see RQ4

    property p_sclk_input;
        @(posedge mclk_in) disable iff (!arst_n_in)
        mode1 |=> !shift_clock_pin_oe_out;
    endproperty
    a_sclk_input: assert property (p_sclk_input) else $error("shift clock driven in mode 1"); // see RQ5

    property p_sections;
        @(posedge mclk_in) disable iff (!arst_n_in)
        !full_pd |=> fsk_power_down_out != tone_power_down_out;
    endproperty
    a_sections: assert property (p_sections) else $error("section power wrong"); // see RQ8

    property p_ready_low;
        @(posedge mclk_in) disable iff (!arst_n_in)
        word_done && fsk_sel && !full_pd |=> !word_ready_or_delayed_steer_n_out;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("word ready not low"); // see RQ12

    property p_read_clears;
        @(posedge mclk_in) disable iff (!arst_n_in)
        sclk_rise && !word_done && fsk_sel && !full_pd |=> word_ready_or_delayed_steer_n_out;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // see RQ13

    property p_shift_advance;
        @(posedge mclk_in) disable iff (!arst_n_in)
        sclk_rise && !word_done |=> data_out == $past(shift_r[1]);
    endproperty
    a_shift_advance: assert property (p_shift_advance) else $error("shift did not advance"); // see RQ14

    c_word: cover property (@(posedge mclk_in) disable iff (!arst_n_in) word_done && mode1);
    c_framing: cover property (@(posedge mclk_in) disable iff (!arst_n_in) word_done && !fsk_bit_in);
    c_read: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
        !word_ready_or_delayed_steer_n_out && sclk_rise);

endmodule : fsk_serial_data_interface

/* File: inc/fsk_if_pkg.sv */
package fsk_if_pkg;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_INT_STATUS = 8'h08;
    localparam logic [7:0] REG_INT_MASK = 8'h0c;
    localparam logic [7:0] REG_LAST_WORD = 8'h10;

    // Field positions
    localparam int CTRL_RX_ENABLE_BIT = 0;
    localparam int INT_WORD_BIT = 0;
    localparam int INT_FRAMING_BIT = 1;
    localparam int INT_OVERRUN_BIT = 2;
    localparam int INT_WIDTH = 3;

    // Reset values
    localparam logic CTRL_RESET = 1'b1;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;
    localparam logic [8:0] WORD_RESET = 9'h1ff;

    // Bit timing in oscillator ticks
    localparam int OSC_HZ = 3579545;
    localparam int BAUD = 1200;
    localparam logic [11:0] BIT_TICKS = 12'((OSC_HZ + BAUD / 2) / BAUD);
    localparam logic [11:0] HALF_TICKS = 12'(((OSC_HZ + BAUD / 2) / BAUD) / 2);
    localparam logic [11:0] STROBE_TICKS = 12'(((OSC_HZ + BAUD / 2) / BAUD) / 4);
    localparam int DATA_BITS = 8;

    // AXI4-Lite response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

endpackage : fsk_if_pkg

/* File: bench/fsk_host_model.sv */
`timescale 1ns/1ps
module fsk_host_model #(
    parameter int DELAY_CYCLES = 1000
) (
    // Clock and control
    input wire logic mclk_in,
    input wire logic armed_in,
    // Serial interface
    input wire logic word_ready_n_in,
    input wire logic data_in,
    output logic sclk_out,
    // Result
    output logic [8:0] word_out,
    output logic done_out
);
    logic [8:0] word;

    initial begin
        sclk_out = 1'b0;
        word_out = 9'h000;
        done_out = 1'b0;
        word = 9'h1ff;
        forever begin
            @(posedge mclk_in);
            if (armed_in && word_ready_n_in === 1'b0) begin
                // Bit 0 is on the pin before any pulse
                word[0] = data_in;
                // Slow host lets the request stand a while
                repeat (DELAY_CYCLES) @(posedge mclk_in);
                for (int k = 1; k <= 9; k++) begin
                    // Eight pulses for the byte, a ninth for the stop bit
                    sclk_out <= 1'b1;
                    repeat (2) @(posedge mclk_in);
                    sclk_out <= 1'b0;
                    repeat (2) @(posedge mclk_in);
                    if (k < 9) begin
                        word[k] = data_in;
                    end
                end
                word_out <= word;
                done_out <= 1'b1;
            end
        end
    end
endmodule : fsk_host_model

/* File: bench/fsk_serial_data_interface_tb_top.sv */
`timescale 1ns/1ps
module fsk_serial_data_interface_tb_top;
    import fsk_if_pkg::*;
    localparam int BIT_CYC = 2 * int'(BIT_TICKS);
    localparam logic [7:0] BYTE_VAL = 8'h3a;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    axil_req_t req = '0;
    axil_rsp_t rsp;
    logic sel = 1'b0, fa = 1'b1, fb = 1'b1, osc = 1'b0, fsk_bit = 1'b1, tone = 1'b0;
    logic armed = 1'b0;
    logic irq, sclk_dev, sclk_oe, dout, wr_n, full_pd, fsk_pd, tone_pd, hyb;
    logic host_sclk, host_done;
    logic [8:0] host_word;
    wire logic sclk_pin = sclk_oe ? sclk_dev : host_sclk;
    int fails = 0;
    int checked = 0;
    int n;

    always #4 clk = ~clk;
    // Oscillator at half the bus clock keeps a frame near 60k cycles
    always @(posedge clk) osc <= ~osc;

    fsk_serial_data_interface fsk_serial_data_interface_i (
        .mclk_in(clk), .arst_n_in(rst_n), .axil_req_in(req), .axil_rsp_out(rsp),
        .irq_out(irq), .interface_select_in(sel), .function_select_a_in(fa),
        .function_select_b_in(fb), .oscillator_input_in(osc), .fsk_bit_in(fsk_bit),
        .carrier_detect_n_in(1'b0), .tone_detect_in(tone), .shift_clock_pin_in(sclk_pin),
        .shift_clock_pin_out(sclk_dev), .shift_clock_pin_oe_out(sclk_oe), .data_out(dout),
        .word_ready_or_delayed_steer_n_out(wr_n), .full_power_down_out(full_pd),
        .fsk_power_down_out(fsk_pd), .tone_power_down_out(tone_pd),
        .tone_use_hybrid_out(hyb));

    fsk_host_model fsk_host_model_i (
        .mclk_in(clk), .armed_in(armed), .word_ready_n_in(wr_n), .data_in(dout),
        .sclk_out(host_sclk), .word_out(host_word), .done_out(host_done));

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask : tick

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        // One edge between transfers so no strobe is driven twice in a step
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && rsp.awready === 1'b1) begin
                aw_ok = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (!w_ok && rsp.wready === 1'b1) begin
                w_ok = 1'b1;
                req.wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        chk({30'h0, rsp.bresp}, {30'h0, er});
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(posedge clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge clk); while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        chk(rsp.rdata, exp);
        chk({30'h0, rsp.rresp}, {30'h0, er});
    endtask : axi_rd

    task automatic send_bit(input logic b);
        fsk_bit <= b;
        tick(BIT_CYC);
    endtask : send_bit

    initial begin
        tick(5);
        rst_n <= 1'b1;
        tick(1);
        chk1(dout, 1'b1);
        chk1(wr_n, 1'b1);
        axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
        axi_rd(REG_INT_MASK, 32'h0, RESP_OKAY);
        axi_rd(REG_LAST_WORD, 32'h1ff, RESP_OKAY);
        axi_rd(REG_STATUS, 32'h6a, RESP_OKAY);
        axi_rd(8'h14, 32'h0, RESP_SLVERR);
        axi_wr(8'h14, 32'h1, RESP_SLVERR);
        // Every select combination; tone held so the steer output shows it
        tone <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            {sel, fa, fb} <= 3'(i);
            tick(3);
            chk1(full_pd, i == 4);
            chk1(fsk_pd, !(i[1] == i[0] && i != 4));
            chk1(tone_pd, (i[1] == i[0]) || i == 4);
            chk1(hyb, i[1] & ~i[0]);
            if (i[1] != i[0]) begin
                chk1(wr_n, 1'b0);
            end
        end
        tone <= 1'b0;
        {sel, fa, fb} <= 3'b011;
        tick(3);
        chk1(sclk_oe, 1'b1);
        fsk_bit <= 1'b0;
        tick(6);
        chk1(dout, 1'b0);
        n = 6;
        while (sclk_dev !== 1'b1) begin
            tick(1);
            n++;
        end
        chk1(n >= 2978 && n <= 2995, 1'b1);
        n = 0;
        while (sclk_dev === 1'b1) begin
            tick(1);
            n++;
        end
        chk1(n >= 1486 && n <= 1494, 1'b1);
        fsk_bit <= 1'b1;
        // Idling the receiver abandons the half-read word
        axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
        axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
        {sel, fa, fb} <= 3'b111;
        armed <= 1'b1;
        tick(3);
        chk1(sclk_oe, 1'b0);
        axi_wr(REG_INT_MASK, 32'h1, RESP_OKAY);
        chk1(irq, 1'b0);
        send_bit(1'b0);
        for (int k = 0; k < 8; k++) begin
            send_bit(BYTE_VAL[k]);
        end
        // Stop bit held as idle mark; word ready falls at its centre
        fsk_bit <= 1'b1;
        while (wr_n !== 1'b0) tick(1);
        chk1(dout, BYTE_VAL[0]);
        while (host_sclk !== 1'b1) tick(1);
        chk1(wr_n, 1'b0);
        tick(2);
        chk1(wr_n, 1'b1);
        while (host_done !== 1'b1) tick(1);
        chk({23'h0, host_word}, {24'h1, BYTE_VAL});
        chk1(dout, 1'b1);
        chk1(irq, 1'b1);
        axi_rd(REG_INT_STATUS, 32'h1, RESP_OKAY);
        axi_rd(REG_LAST_WORD, {24'h1, BYTE_VAL}, RESP_OKAY);
        axi_wr(REG_INT_MASK, 32'h0, RESP_OKAY);
        tick(2);
        chk1(irq, 1'b0);
        axi_wr(REG_INT_MASK, 32'h1, RESP_OKAY);
        tick(2);
        chk1(irq, 1'b1);
        axi_wr(REG_INT_STATUS, 32'h1, RESP_OKAY);
        tick(2);
        chk1(irq, 1'b0);
        axi_rd(REG_INT_STATUS, 32'h0, RESP_OKAY);
        final_report();
    end

    // Whole sequence needs about 62k cycles
    initial begin
        tick(95000);
        fails++;
        final_report();
    end
endmodule : fsk_serial_data_interface_tb_top
